//--- include/rtw_pkg.sv
package rtw_pkg;
  localparam logic [3:0]  REG_TRIM_ADDR   = 4'h7;
  localparam logic [3:0]  REG_WMIN_ADDR   = 4'h8;
  localparam logic [3:0]  REG_WHOUR_ADDR  = 4'h9;
  localparam logic [3:0]  REG_WDAY_ADDR   = 4'hA;
  localparam int          TRIM_DEV_BIT    = 7;
  localparam int          TRIM_SIGN_BIT   = 6;
  localparam int          TRIM_MAG_W      = 6;
  localparam int          WMIN_W          = 7;
  localparam int          WHOUR_W         = 6;
  localparam int          WDAY_W          = 7;
  localparam logic [7:0]  TRIM_RESET      = 8'h00;
  localparam logic [15:0] BASE_COUNT      = 16'h8000;
  localparam logic [6:0]  SEC_POINT0      = 7'h00;
  localparam logic [6:0]  SEC_POINT1      = 7'h20;
  localparam logic [6:0]  SEC_POINT2      = 7'h40;
  localparam int          CLK_MHZ         = 125;
  localparam int          WALARM_DELAY_NS = 31000;
  localparam int          WALARM_DELAY_CYC = WALARM_DELAY_NS * CLK_MHZ / 1000;

  typedef struct packed {
    logic [6:0] second;
    logic [6:0] minute;
    logic [5:0] hour;
    logic [2:0] weekday;
  } rtw_time_s;
endpackage

//--- logic/rtw_trim_div.sv
`timescale 1ns/1ns
`default_nettype none
module rtw_trim_div #(
  parameter logic [15:0] SEC_COUNT = rtw_pkg::BASE_COUNT
) (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       osc_rise_i,
  input  wire logic [7:0] trim_i,
  input  wire logic       trim_wr_i,
  input  wire logic [6:0] second_i,
  output logic            sec_tick_o
);
  import rtw_pkg::*;

  logic [15:0] cnt_ff;
  logic        wr_seen_ff;
  logic        tick_ff;
  logic        is_point;
  logic        mag_zero;
  logic        apply;
  logic        tick_end;
  logic [5:0]  mag;
  logic [5:0]  mag_inv;
  logic [15:0] nxt_len;

  assign mag      = trim_i[TRIM_MAG_W-1:0];
  // kept at six bits so a widening cast cannot invert the padding
  assign mag_inv  = ~mag;
  assign mag_zero = (mag[TRIM_MAG_W-1:1] == 5'h00);
  assign is_point = (second_i == SEC_POINT0) |
                    (!trim_i[TRIM_DEV_BIT] &
                     ((second_i == SEC_POINT1) |
                      (second_i == SEC_POINT2)));
  assign apply    = is_point & !mag_zero & !wr_seen_ff & !trim_wr_i;

  always_comb begin
    nxt_len = SEC_COUNT;
    if (apply) begin
      if (trim_i[TRIM_SIGN_BIT]) begin
        nxt_len = SEC_COUNT - {8'h00, {1'b0, ~mag} + 7'h01, 1'b0};
      end else begin
        nxt_len = SEC_COUNT + {9'h000, mag - 6'h01, 1'b0};
      end
    end
  end

  // >= so a mid-second trim rewrite can never leave the count stranded
  assign tick_end = osc_rise_i & (cnt_ff >= nxt_len - 16'h0001);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_ff <= 16'h0000;
    end else if (tick_end) begin
      cnt_ff <= 16'h0000;
    end else if (osc_rise_i) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  // a write in the tick cycle wins and protects the following second
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_seen_ff <= 1'b0;
    end else if (trim_wr_i) begin
      wr_seen_ff <= 1'b1;
    end else if (tick_end) begin
      wr_seen_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= tick_end;
    end
  end

  assign sec_tick_o = tick_ff;

  property p_nopoint_base;
    @(posedge clk_i) disable iff (!reset_n_i)
      tick_end && !is_point |-> cnt_ff == SEC_COUNT - 16'h0001;
  endproperty
  a_nopoint_base: assert property (p_nopoint_base)
    else $error("non-correction second not 32768 counts");

  property p_zero_mag;
    @(posedge clk_i) disable iff (!reset_n_i)
      tick_end && mag_zero && !wr_seen_ff |-> cnt_ff == SEC_COUNT - 16'h0001;
  endproperty
  a_zero_mag: assert property (p_zero_mag)
    else $error("zero magnitude altered the second");

  property p_lengthen;
    @(posedge clk_i) disable iff (!reset_n_i)
      tick_end && apply && !trim_i[TRIM_SIGN_BIT] |->
        32'(cnt_ff) == 32'(SEC_COUNT) - 1 + 2 * (32'(mag) - 1);
  endproperty
  a_lengthen: assert property (p_lengthen)
    else $error("lengthened second has wrong count");

  property p_shorten;
    @(posedge clk_i) disable iff (!reset_n_i)
      tick_end && apply && trim_i[TRIM_SIGN_BIT] |->
        32'(cnt_ff) == 32'(SEC_COUNT) - 1 - 2 * (32'(mag_inv) + 1);
  endproperty
  a_shorten: assert property (p_shorten)
    else $error("shortened second has wrong count");

  property p_skip_write;
    @(posedge clk_i) disable iff (!reset_n_i)
      tick_end && wr_seen_ff |-> cnt_ff >= SEC_COUNT - 16'h0001;
  endproperty
  a_skip_write: assert property (p_skip_write)
    else $error("second shortened despite trim write");
endmodule
`default_nettype wire

//--- logic/rtw_top.sv
`timescale 1ns/1ns
`default_nettype none
// the oscillator counts per untrimmed second; a bench may shorten it
module rtw_top #(
  parameter logic [15:0] SEC_COUNT = rtw_pkg::BASE_COUNT
) (
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              osc_32k_i,
  input  wire logic              power_on_flag_i,
  input  wire logic              walarm_enable_i,
  input  wire rtw_pkg::rtw_time_s time_i,
  input  wire logic              minute_roll_i,
  input  wire logic [3:0]        reg_addr_i,
  input  wire logic              reg_we_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              flag_wr_i,
  input  wire logic              flag_wdata_i,
  output logic [7:0]             reg_rdata_o,
  output logic                   sec_tick_o,
  output logic                   clk32k_o,
  output logic                   walarm_flag_o
);
  import rtw_pkg::*;

  localparam int DLY_W = 12;
  localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(WALARM_DELAY_CYC - 1);

  logic               osc_s1_ff;
  logic               osc_s2_ff;
  logic               osc_s3_ff;
  logic               osc_rise;
  logic               pon_d_ff;
  logic               pon_rise;
  logic               trim_wr;
  logic [7:0]         trim_ff;
  logic [WMIN_W-1:0]  wmin_ff;
  logic [WHOUR_W-1:0] whour_ff;
  logic [WDAY_W-1:0]  wday_ff;
  logic [7:0]         rdata_ff;
  logic [7:0]         day_ext;
  logic               match;
  logic               start;
  logic               dly_busy_ff;
  logic [DLY_W-1:0]   dly_cnt_ff;
  logic               flag_set;
  logic               flag_ff;
  logic [DLY_W-1:0]   gap_ff;

  // oscillator pin crosses into clk_i; the second and third stages are read
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      osc_s1_ff <= 1'b0;
      osc_s2_ff <= 1'b0;
      osc_s3_ff <= 1'b0;
    end else begin
      osc_s1_ff <= osc_32k_i;
      osc_s2_ff <= osc_s1_ff;
      osc_s3_ff <= osc_s2_ff;
    end
  end

  assign osc_rise = osc_s2_ff & ~osc_s3_ff;
  // clock output taps the oscillator ahead of the trimmer
  assign clk32k_o = osc_s2_ff;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pon_d_ff <= 1'b0;
    end else begin
      pon_d_ff <= power_on_flag_i;
    end
  end

  assign pon_rise = power_on_flag_i & ~pon_d_ff;
  assign trim_wr  = reg_we_i & (reg_addr_i == REG_TRIM_ADDR);

  // power-on clear outranks a write landing in the same cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trim_ff <= TRIM_RESET;
    end else if (pon_rise) begin
      trim_ff <= TRIM_RESET;
    end else if (trim_wr) begin
      trim_ff <= reg_wdata_i;
    end
  end

  // alarm registers have no power-on value for software; zeroed on reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wmin_ff  <= '0;
      whour_ff <= '0;
      wday_ff  <= '0;
    end else if (reg_we_i) begin
      if (reg_addr_i == REG_WMIN_ADDR) begin
        wmin_ff <= reg_wdata_i[WMIN_W-1:0];
      end else if (reg_addr_i == REG_WHOUR_ADDR) begin
        whour_ff <= reg_wdata_i[WHOUR_W-1:0];
      end else if (reg_addr_i == REG_WDAY_ADDR) begin
        wday_ff <= reg_wdata_i[WDAY_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_ff <= 8'h00;
    end else if (reg_addr_i == REG_TRIM_ADDR) begin
      rdata_ff <= trim_ff;
    end else if (reg_addr_i == REG_WMIN_ADDR) begin
      rdata_ff <= {1'b0, wmin_ff};
    end else if (reg_addr_i == REG_WHOUR_ADDR) begin
      rdata_ff <= {2'b00, whour_ff};
    end else if (reg_addr_i == REG_WDAY_ADDR) begin
      rdata_ff <= {1'b0, wday_ff};
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata_o = rdata_ff;

  // plain code equality keeps 12 as midnight and 32 as noon in 12-hour mode
  assign day_ext = {1'b0, wday_ff};
  assign match   = (time_i.minute == wmin_ff) &
                   (time_i.hour == whour_ff) &
                   day_ext[time_i.weekday];
  // values are taken in the rollover cycle itself, one event per minute
  assign start   = minute_roll_i & walarm_enable_i & match;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dly_busy_ff <= 1'b0;
      dly_cnt_ff  <= '0;
    end else if (start) begin
      dly_busy_ff <= 1'b1;
      dly_cnt_ff  <= '0;
    end else if (dly_busy_ff) begin
      if (dly_cnt_ff == DLY_LAST) begin
        dly_busy_ff <= 1'b0;
      end else begin
        dly_cnt_ff <= dly_cnt_ff + 1'b1;
      end
    end
  end

  assign flag_set = dly_busy_ff & (dly_cnt_ff == DLY_LAST);

  // set beats a clear written in the same cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_ff <= 1'b0;
    end else if (flag_set) begin
      flag_ff <= 1'b1;
    end else if (flag_wr_i && !flag_wdata_i) begin
      flag_ff <= 1'b0;
    end
  end

  // flag reads 0 while the alarm is disabled
  assign walarm_flag_o = flag_ff & walarm_enable_i;

  rtw_trim_div #(
    .SEC_COUNT (SEC_COUNT)
  ) u_trim_div (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .osc_rise_i (osc_rise),
    .trim_i     (trim_ff),
    .trim_wr_i  (trim_wr),
    .second_i   (time_i.second),
    .sec_tick_o (sec_tick_o)
  );

  // helper for the delay check: cycles since the last alarm match
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gap_ff <= '0;
    end else if (start) begin
      gap_ff <= '0;
    end else if (gap_ff != '1) begin
      gap_ff <= gap_ff + 1'b1;
    end
  end

  property p_trim_por;
    @(posedge clk_i) disable iff (!reset_n_i)
      pon_rise |=> trim_ff == 8'h00;
  endproperty
  a_trim_por: assert property (p_trim_por)
    else $error("trim not cleared by power-on flag");

  property p_flag_delay;
    @(posedge clk_i) disable iff (!reset_n_i)
      flag_set |-> gap_ff == 12'(WALARM_DELAY_CYC - 1);
  endproperty
  a_flag_delay: assert property (p_flag_delay)
    else $error("alarm flag set at wrong delay after match");

  property p_no_early_flag;
    @(posedge clk_i) disable iff (!reset_n_i)
      start |=> !flag_set [*8];
  endproperty
  a_no_early_flag: assert property (p_no_early_flag)
    else $error("alarm flag set too early");

  property p_mask_zero;
    @(posedge clk_i) disable iff (!reset_n_i)
      minute_roll_i && wday_ff == 7'h00 && !dly_busy_ff |=> !dly_busy_ff;
  endproperty
  a_mask_zero: assert property (p_mask_zero)
    else $error("match raised with empty day mask");

  property p_write_one;
    @(posedge clk_i) disable iff (!reset_n_i)
      !flag_ff && !flag_set && flag_wr_i && flag_wdata_i |=> !flag_ff;
  endproperty
  a_write_one: assert property (p_write_one)
    else $error("writing 1 set the alarm flag");

  property p_write_zero;
    @(posedge clk_i) disable iff (!reset_n_i)
      flag_wr_i && !flag_wdata_i && !flag_set |=> !flag_ff;
  endproperty
  a_write_zero: assert property (p_write_zero)
    else $error("writing 0 did not clear the alarm flag");

  property p_unused_bits;
    @(posedge clk_i) disable iff (!reset_n_i)
      $past(reg_addr_i) == REG_WHOUR_ADDR |-> reg_rdata_o[7:6] == 2'b00;
  endproperty
  a_unused_bits: assert property (p_unused_bits)
    else $error("unused alarm hour bits read nonzero");
endmodule
`default_nettype wire

//--- tb/rtw_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module rtw_host_model (
  input  wire logic       clk_i,
  output logic [3:0]      reg_addr_o,
  output logic            reg_we_o,
  output logic [7:0]      reg_wdata_o,
  output logic            flag_wr_o,
  output logic            flag_wdata_o,
  input  wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_addr_o   = 4'h0;
    reg_we_o     = 1'b0;
    reg_wdata_o  = 8'h00;
    flag_wr_o    = 1'b0;
    flag_wdata_o = 1'b1;
  end

  // callers pass valid bcd times to the alarm registers, except the 8'hFF register access test
  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_o  <= a;
    reg_we_o    <= 1'b1;
    reg_wdata_o <= d;
    @(posedge clk_i);
    reg_we_o    <= 1'b0;
    // released data must not keep showing the last value
    reg_wdata_o <= ~d;
  endtask

  task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    @(posedge clk_i);
    // answer launched at the edge above is taken at the next one
    @(posedge clk_i);
    d = reg_rdata_i;
  endtask

  task automatic write_flag(input logic v);
    @(posedge clk_i);
    flag_wr_o    <= 1'b1;
    flag_wdata_o <= v;
    @(posedge clk_i);
    flag_wr_o    <= 1'b0;
    flag_wdata_o <= ~v;
  endtask
endmodule
`default_nettype wire

//--- tb/rtw_trim_and_weekly_alarm_bench.sv
`timescale 1ns/1ns
`default_nettype none
module rtw_trim_and_weekly_alarm_bench;
  import rtw_pkg::*;
  logic       clk_i           = 1'b0;
  logic       reset_n_i       = 1'b0;
  logic       osc_32k_i       = 1'b0;
  logic       power_on_flag_i = 1'b0;
  logic       walarm_enable_i = 1'b0;
  rtw_time_s  time_i          = '0;
  logic       minute_roll_i   = 1'b0;
  logic [3:0] reg_addr_i;
  logic       reg_we_i;
  logic [7:0] reg_wdata_i;
  logic       flag_wr_i;
  logic       flag_wdata_i;
  logic [7:0] reg_rdata_o;
  logic       sec_tick_o;
  logic       clk32k_o;
  logic       walarm_flag_o;
  int         num_errors      = 0;
  int         total_checks    = 0;
  int         osc_rises       = 0;
  int         tick_mark       = 0;
  // short second keeps every trim case inside the cycle budget
  localparam logic [15:0] SEC_LEN = 16'h0040;
  logic [7:0] wr_exp [4]      = '{8'hFF, 8'h7F, 8'h3F, 8'h7F};

  always #4 clk_i = ~clk_i;
  // 125 ns period, unrelated in phase to the system clock
  // non-blocking, so an edge that meets a clock edge is seen after it
  always begin
    #63 osc_32k_i <= 1'b1;
    #62 osc_32k_i <= 1'b0;
  end

  always @(posedge osc_32k_i) osc_rises++;

  rtw_top #(.SEC_COUNT(SEC_LEN)) uut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .osc_32k_i(osc_32k_i),
    .power_on_flag_i(power_on_flag_i), .walarm_enable_i(walarm_enable_i),
    .time_i(time_i), .minute_roll_i(minute_roll_i),
    .reg_addr_i(reg_addr_i), .reg_we_i(reg_we_i),
    .reg_wdata_i(reg_wdata_i), .flag_wr_i(flag_wr_i),
    .flag_wdata_i(flag_wdata_i), .reg_rdata_o(reg_rdata_o),
    .sec_tick_o(sec_tick_o), .clk32k_o(clk32k_o),
    .walarm_flag_o(walarm_flag_o)
  );

  rtw_host_model host (
    .clk_i(clk_i), .reg_addr_o(reg_addr_i), .reg_we_o(reg_we_i),
    .reg_wdata_o(reg_wdata_i), .flag_wr_o(flag_wr_i),
    .flag_wdata_o(flag_wdata_i), .reg_rdata_i(reg_rdata_o)
  );

  task automatic check8(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check1(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check16(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // oscillator rises between two ticks; optional trim write just after the opening tick
  task automatic sec_len(input logic wr, input logic [7:0] t,
                         input logic [15:0] exp);
    int start;
    start = tick_mark;
    if (wr) begin
      host.write_reg(REG_TRIM_ADDR, t);
    end
    @(posedge clk_i iff sec_tick_o);
    tick_mark = osc_rises;
    check16("second length", exp, 16'(tick_mark - start));
  endtask

  task automatic rd_check(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.read_reg(a, d);
    check8($sformatf("register %h", a), exp, d);
  endtask

  // one minute rollover, then the flag is watched around its set edge
  task automatic run_alarm(input logic [6:0] m, input logic [5:0] h,
                           input logic [2:0] wd, input logic exp);
    @(posedge clk_i);
    time_i        <= '{second: 7'h00, minute: m, hour: h, weekday: wd};
    minute_roll_i <= 1'b1;
    @(posedge clk_i);
    minute_roll_i <= 1'b0;
    repeat (3874) @(posedge clk_i);
    #1 check1("alarm flag before delay", 1'b0, walarm_flag_o);
    repeat (2) @(posedge clk_i);
    #1 check1("alarm flag after delay", exp, walarm_flag_o);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int a = 7; a < 12; a++) begin
      rd_check(a[3:0], 8'h00);
    end
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      host.write_reg(REG_TRIM_ADDR + 4'(i), 8'hFF);
      rd_check(REG_TRIM_ADDR + 4'(i), wr_exp[i]);
    end
    $display("test register access done");
    host.write_reg(REG_TRIM_ADDR, 8'h87);
    @(posedge clk_i);
    power_on_flag_i <= 1'b1;
    rd_check(REG_TRIM_ADDR, TRIM_RESET);
    rd_check(REG_WMIN_ADDR, 8'h7F);
    power_on_flag_i <= 1'b0;
    $display("test power-on clear done");
    host.write_reg(REG_WMIN_ADDR, 8'h30);
    host.write_reg(REG_WHOUR_ADDR, 8'h32);
    host.write_reg(REG_WDAY_ADDR, 8'h40);
    walarm_enable_i <= 1'b1;
    run_alarm(7'h30, 6'h32, 3'h6, 1'b1);
    host.write_flag(1'b1);
    #1 check1("flag after writing one", 1'b1, walarm_flag_o);
    host.write_flag(1'b0);
    #1 check1("flag after writing zero", 1'b0, walarm_flag_o);
    $display("test alarm match done");
    run_alarm(7'h30, 6'h12, 3'h6, 1'b0);
    run_alarm(7'h30, 6'h32, 3'h5, 1'b0);
    host.write_reg(REG_WDAY_ADDR, 8'h00);
    run_alarm(7'h30, 6'h32, 3'h6, 1'b0);
    $display("test alarm mismatch done");
    for (int i = 0; i < 3; i++) begin
      @(posedge osc_32k_i);
      repeat (4) @(posedge clk_i);
      #1 check1("clock output high", 1'b1, clk32k_o);
      @(negedge osc_32k_i);
      repeat (4) @(posedge clk_i);
      #1 check1("clock output low", 1'b0, clk32k_o);
    end
    $display("test clock output done");
    @(posedge clk_i iff sec_tick_o);
    tick_mark = osc_rises;
    sec_len(1'b0, 8'h00, SEC_LEN);
    sec_len(1'b1, 8'h07, SEC_LEN);
    sec_len(1'b0, 8'h00, SEC_LEN + 16'h000C);
    sec_len(1'b1, 8'h7E, SEC_LEN);
    sec_len(1'b0, 8'h00, SEC_LEN - 16'h0004);
    sec_len(1'b1, 8'h41, SEC_LEN);
    sec_len(1'b0, 8'h00, SEC_LEN);
    time_i.second <= 7'h20;
    sec_len(1'b1, 8'h87, SEC_LEN);
    sec_len(1'b0, 8'h00, SEC_LEN);
    sec_len(1'b1, 8'h07, SEC_LEN);
    sec_len(1'b0, 8'h00, SEC_LEN + 16'h000C);
    $display("test time-count trim done");
    final_report();
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    num_errors++;
    $display("ERROR watchdog expected done seen hang");
    final_report();
  end
endmodule
`default_nettype wire
